// ---- mrcm_ctrl.sv ----
module mrcm_ctrl
   import mrcm_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic ref_clk_i,
   input wire logic loss_of_signal_i,
   input wire logic line_clk_i,
   input wire logic line_pos_i,
   input wire logic line_neg_i,
   input wire logic transmit_all_ones_i,
   input wire logic tx_data_i,
   input wire logic host_access_i,
   output logic [1:0] ref_mode_o,
   output logic recovery_en_o,
   output logic jitter_ref_tick_o,
   output logic rx_powerdown_o,
   output logic recovered_clk_o,
   output logic recovered_clk_oe_o,
   output logic receive_positive_data_o,
   output logic receive_negative_data_o,
   output logic receive_data_oe_o,
   output logic tx_ones_tick_o,
   output logic tx_data_o,
   output logic host_ready_o,
   output logic host_ready_oe_o
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic ref_s;
   logic los_s;
   logic lclk_s;
   logic lpos_s;
   logic lneg_s;
   logic transmit_all_ones_s;
   logic txd_s;
   logic hacc_s;

   mrcm_sync u_sync_ref (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .async_i(ref_clk_i), .sync_o(ref_s));
   mrcm_sync u_sync_los (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .async_i(loss_of_signal_i), .sync_o(los_s));
   mrcm_sync u_sync_lclk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .async_i(line_clk_i), .sync_o(lclk_s));
   mrcm_sync u_sync_lpos (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .async_i(line_pos_i), .sync_o(lpos_s));
   mrcm_sync u_sync_lneg (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .async_i(line_neg_i), .sync_o(lneg_s));
   mrcm_sync u_sync_transmit_all_ones (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .async_i(transmit_all_ones_i), .sync_o(transmit_all_ones_s));
   mrcm_sync u_sync_txd (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .async_i(tx_data_i), .sync_o(txd_s));
   mrcm_sync u_sync_hacc (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .async_i(host_access_i), .sync_o(hacc_s));

   // ----------------------------------------
   // Edge-activity classifier
   // ----------------------------------------
   logic ref_d_reg;
   logic [TMO_W-1:0] tmo_reg;
   logic [TMO_W-1:0] tmo_next;
   logic [2:0] edge_cnt_reg;
   logic [2:0] edge_cnt_next;
   mrcm_mode_t mode_reg;
   mrcm_mode_t mode_next;

   wire ref_edge = ref_s ^ ref_d_reg;
   wire ref_rise = ref_s & ~ref_d_reg;
   wire timeout = (tmo_reg >= TMO_LIMIT);
   wire edges_full = (edge_cnt_reg == EDGE_SETTLE);

   assign tmo_next = ref_edge ? TMO_RST :
      (timeout ? tmo_reg : tmo_reg + 8'h01);
   assign edge_cnt_next = timeout ? EDGE_RST :
      ((ref_edge && !edges_full) ? edge_cnt_reg + 3'h1 : edge_cnt_reg);

   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         MRCM_REF_TOGGLE:
            if (timeout)
               mode_next = ref_s ? MRCM_REF_HIGH : MRCM_REF_LOW;
         default:
            if (edges_full && !timeout)
               mode_next = MRCM_REF_TOGGLE;
            // First edge after idle keeps the class
            else if (timeout && !ref_edge)
               mode_next = ref_s ? MRCM_REF_HIGH : MRCM_REF_LOW;
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         ref_d_reg <= 1'b0;
         tmo_reg <= TMO_RST;
         edge_cnt_reg <= EDGE_RST;
         mode_reg <= MRCM_REF_LOW;
      end
      else
      begin
         ref_d_reg <= ref_s;
         tmo_reg <= tmo_next;
         edge_cnt_reg <= edge_cnt_next;
         mode_reg <= mode_next;
      end
   end

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   wire is_tog = (mode_reg == MRCM_REF_TOGGLE);
   wire is_high = (mode_reg == MRCM_REF_HIGH);
   wire is_low = (mode_reg == MRCM_REF_LOW);
   wire rclk_next = (is_tog && los_s) ? ref_s : lclk_s;
   wire tx_next = (is_tog && transmit_all_ones_s) ? 1'b1 : txd_s;
   wire ones_tick_next = is_tog && transmit_all_ones_s && ref_rise;
   wire jit_next = is_tog && ref_rise;

   // ----------------------------------------
   // Wait-state generation
   // ----------------------------------------
   logic [3:0] wait_cnt_reg;
   logic [3:0] wait_cnt_next;
   logic hacc_d_reg;
   wire acc_start = hacc_s & ~hacc_d_reg;
   wire wait_busy = (wait_cnt_reg != 4'h0);

   assign wait_cnt_next = (acc_start && is_tog) ? WAIT_REF_EDGES :
      ((wait_busy && ref_rise) ? wait_cnt_reg - 4'h1 : wait_cnt_reg);

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         hacc_d_reg <= 1'b0;
         wait_cnt_reg <= 4'h0;
         ref_mode_o <= 2'h0;
         recovery_en_o <= 1'b0;
         jitter_ref_tick_o <= 1'b0;
         rx_powerdown_o <= 1'b1;
         recovered_clk_o <= 1'b0;
         recovered_clk_oe_o <= 1'b0;
         receive_positive_data_o <= 1'b0;
         receive_negative_data_o <= 1'b0;
         receive_data_oe_o <= 1'b0;
         tx_ones_tick_o <= 1'b0;
         tx_data_o <= 1'b0;
         host_ready_o <= 1'b0;
         host_ready_oe_o <= 1'b0;
      end
      else
      begin
         hacc_d_reg <= hacc_s;
         wait_cnt_reg <= is_tog ? wait_cnt_next : 4'h0;
         ref_mode_o <= mode_reg;
         recovery_en_o <= is_tog;
         jitter_ref_tick_o <= jit_next;
         rx_powerdown_o <= is_low;
         recovered_clk_o <= is_low ? 1'b0 : rclk_next;
         recovered_clk_oe_o <= !is_low;
         receive_positive_data_o <= is_low ? 1'b0 : lpos_s;
         receive_negative_data_o <= is_low ? 1'b0 : lneg_s;
         receive_data_oe_o <= !is_low;
         tx_ones_tick_o <= ones_tick_next;
         tx_data_o <= tx_next;
         host_ready_o <= is_tog && hacc_s && !wait_busy && !acc_start;
         host_ready_oe_o <= is_tog && hacc_s;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_low_tristate:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      is_low |=> !recovered_clk_oe_o && !receive_data_oe_o && rx_powerdown_o)
      else $error("static low did not tristate receive outputs");

   chk_high_norecov:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      is_high |=> !recovery_en_o && receive_data_oe_o)
      else $error("static high left recovery enabled");

   chk_tog_recov:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      is_tog |=> recovery_en_o && !rx_powerdown_o)
      else $error("toggling reference did not enable recovery");

   chk_los_refclk:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (is_tog && los_s) |=> recovered_clk_o == $past(ref_s))
      else $error("recovered clock not taken from reference in LOS");

   chk_transmit_all_ones_ones:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (is_tog && transmit_all_ones_s) |=> tx_data_o)
      else $error("all-ones not sent");

   chk_wait_absent:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !is_tog |=> !host_ready_oe_o && !host_ready_o)
      else $error("wait-state signalling without reference");

   chk_timeout_leave:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (is_tog && timeout) |=> !is_tog)
      else $error("mode kept toggling after timeout");

   chk_settle_enter:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (!is_tog && !edges_full) |=> !is_tog)
      else $error("toggle mode entered before edges settled");

   chk_idle_edge_hold:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (!is_tog && timeout && ref_edge) |=> mode_reg == $past(mode_reg))
      else $error("static class flipped on first reference edge");

endmodule // mrcm_ctrl

// ---- mrcm_pkg.sv ----
package mrcm_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int REF_T1_KHZ = 1544;
   localparam int REF_E1_KHZ = 2048;
   // Slowest reference period, in system cycles (rounded up)
   localparam int REF_EDGE_CYC =
      (SYS_CLK_HZ + REF_T1_KHZ * 1000 - 1) / (REF_T1_KHZ * 1000);
   // Activity timeout: several expected reference periods
   localparam int REF_TIMEOUT_PERIODS = 4;
   localparam int REF_TIMEOUT_CYC = REF_TIMEOUT_PERIODS * REF_EDGE_CYC;
   localparam int TMO_W = 8;
   localparam logic [TMO_W-1:0] TMO_LIMIT = TMO_W'(REF_TIMEOUT_CYC);
   // Edges needed before declaring the reference toggling
   localparam logic [2:0] EDGE_SETTLE = 3'h4;

   // ----------------------------------------
   // Wait-state generation
   // ----------------------------------------
   localparam logic [3:0] WAIT_REF_EDGES = 4'h2;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [TMO_W-1:0] TMO_RST = 8'h00;
   localparam logic [2:0] EDGE_RST = 3'h0;

   typedef enum logic [1:0] {
      MRCM_REF_LOW,
      MRCM_REF_HIGH,
      MRCM_REF_TOGGLE
   } mrcm_mode_t;

endpackage

// ---- mrcm_sync.sv ----
module mrcm_sync
   import mrcm_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic async_i,
   output logic sync_o
);

   logic meta_reg;

   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         meta_reg <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end

endmodule // mrcm_sync

// ---- mrcm_ref_osc.sv ----
module mrcm_ref_osc
(
   input wire logic [1:0] sel_i,
   input wire logic t1_i,
   output logic ref_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------
   // Board oscillator or tie-off
   // ------------------------------
   initial ref_o = 1'b0;
   always
   begin
      if (sel_i == 2'h2)
      begin
         #(t1_i ? 324 : 244) ref_o = ~ref_o;
      end
      else
      begin
         #10 ref_o = sel_i[0];
      end
   end
endmodule // mrcm_ref_osc

// ---- mrcm_ctrl_tb_top.sv ----
module mrcm_ctrl_tb_top
   import mrcm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------
   // Stimulus and wiring
   // ------------------------------
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic los = 1'b0;
   logic acc = 1'b0;
   logic pos = 1'b0;
   logic neg = 1'b0;
   logic t1 = 1'b1;
   logic rc_tog = 1'b0;
   logic tk_seen = 1'b0;
   logic transmit_all_ones = 1'b0;
   logic lclk = 1'b0;
   logic ot_seen = 1'b0;
   logic rdy_early = 1'b0;
   logic dat_bad = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [7:0] lfsr = 8'h0C;
   logic [13:0] exp_q[$];
   int errors = 0;
   int checked = 0;
   event take;
   wire logic ref_clk, rec, tick, pd, rclk, rclk_oe, rd_oe, txd, rdy, rdy_oe;
   wire logic receive_positive_data, receive_negative_data, otk;
   wire logic [1:0] mode;
   wire logic [13:0] obs;
   assign obs = {mode, rec, pd, rclk_oe, rd_oe, txd, rdy_oe, rdy, rc_tog,
      tk_seen, ot_seen, rdy_early, dat_bad};
   always #25 clk_sys_i = ~clk_sys_i;
   function automatic logic [7:0] lfsr_step(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   always @(negedge clk_sys_i)
   begin
      lfsr <= lfsr_step(lfsr);
      pos <= lfsr[0];
      neg <= lfsr[1];
      lclk <= lfsr[2] & ~los;
   end
   mrcm_ref_osc i_ref (.sel_i(sel), .t1_i(t1), .ref_o(ref_clk));
   mrcm_ctrl i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .ref_clk_i(ref_clk), .loss_of_signal_i(los), .line_clk_i(lclk),
      .line_pos_i(pos), .line_neg_i(neg), .transmit_all_ones_i(transmit_all_ones),
      .tx_data_i(1'b0), .host_access_i(acc), .ref_mode_o(mode),
      .recovery_en_o(rec), .jitter_ref_tick_o(tick), .rx_powerdown_o(pd),
      .recovered_clk_o(rclk), .recovered_clk_oe_o(rclk_oe),
      .receive_positive_data_o(receive_positive_data), .receive_negative_data_o(receive_negative_data),
      .receive_data_oe_o(rd_oe), .tx_ones_tick_o(otk), .tx_data_o(txd),
      .host_ready_o(rdy), .host_ready_oe_o(rdy_oe));
   // ------------------------------
   // Checking and closing
   // ------------------------------
   task automatic check(input logic [13:0] seen, input logic [13:0] want);
      checked++;
      if (seen !== want)
      begin
         errors++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(take)
   begin
      check(obs, exp_q.pop_front());
   end
   // ------------------------------
   // One reference setting
   // ------------------------------
   task automatic run_case(input logic [1:0] s, input logic f,
      input logic l, input logic a);
      int n;
      logic on;
      logic [2:0] h1;
      logic [2:0] h2;
      logic [2:0] e;
      on = (s == 2'h2);
      h1 = 3'h0;
      h2 = 3'h0;
      e = 3'h0;
      @(negedge clk_sys_i);
      sel = s;
      t1 = f;
      los = l;
      transmit_all_ones = a;
      acc = 1'b0;
      n = 0;
      while (mode !== s && n < 400)
      begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n == 400)
      begin
         errors++;
         wrap_up();
      end
      repeat (8) @(negedge clk_sys_i);
      acc = 1'b1;
      rc_tog = 1'b0;
      tk_seen = 1'b0;
      ot_seen = 1'b0;
      rdy_early = 1'b0;
      dat_bad = 1'b0;
      n = 0;
      repeat (60)
      begin
         @(negedge clk_sys_i);
         if (rclk === 1'b1) rc_tog = 1'b1;
         if (tick === 1'b1) tk_seen = 1'b1;
         if (otk === 1'b1) ot_seen = 1'b1;
         if (n < 8 && rdy !== 1'b0) rdy_early = 1'b1;
         e = (s == 2'h0) ? 3'h0 : h2;
         if (n > 1 && {receive_positive_data, receive_negative_data} !== e[1:0]) dat_bad = 1'b1;
         if (n > 1 && !(on && l) && rclk !== e[2]) dat_bad = 1'b1;
         h2 = h1;
         h1 = {lclk, pos, neg};
         n++;
      end
      exp_q.push_back({s, on, s == 2'h0, s != 2'h0, s != 2'h0, on & a, on,
         on, (s != 2'h0) & (on | ~l), on, on & a, 1'b0, 1'b0});
      -> take;
      $display("case sel=%0d t1=%0d los=%0d ones=%0d done", s, f, l, a);
   endtask
   initial
   begin
      repeat (8) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      run_case(2'h2, 1'b1, 1'b1, 1'b1);
      run_case(2'h2, 1'b0, 1'b0, 1'b0);
      run_case(2'h1, 1'b0, 1'b1, 1'b1);
      run_case(2'h1, 1'b1, 1'b0, 1'b0);
      run_case(2'h0, 1'b0, 1'b0, 1'b1);
      run_case(2'h2, 1'b0, 1'b1, 1'b0);
      @(negedge clk_sys_i);
      wrap_up();
   end
endmodule // mrcm_ctrl_tb_top
